// >>> tscc_top.sv
// tscc_top: serial-loaded configuration registers and mode / pa control
// assumes: serial clock is its own domain (sclk_in); mclk_in 20 MHz; load enable and pins async
module tscc_top (
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   input  wire logic        sclk_in,
   input  wire logic        sdata_in,
   input  wire logic        load_en_in,
   input  wire logic        chip_select_pin_in,
   input  wire logic        receive_select_in,
   input  wire logic        pll_locked_in,
   input  wire logic        supply_low_in,
   input  wire logic        pa_request_in,
   input  wire logic        shared_analog_power_pin_in,
   output logic             shared_analog_power_pin_out,
   output logic             shared_analog_power_pin_oe_out,
   output logic             analog_data_drive_out,
   output logic             standby_out,
   output logic             rx_mode_out,
   output logic             tx_mode_out,
   output logic             pa_enable_out,
   output logic             tx_buffer_on_out,
   output logic             cal_start_out,
   output logic             ref_divide_out,
   output logic             charge_pump_invert_out,
   output logic [13:0]      pll_cfg_out,
   output logic [9:0]       chan_int_out,
   output logic [3:0]       chan_frac_out,
   output logic             manual_tune_out,
   output logic [6:0]       filter_tune_out,
   output logic [2:0]       digital_probe_out,
   output logic [2:0]       analog_probe_out
);
   // serial link domain: shift register only
   typedef struct packed {
      logic [15:0] shreg;
   } tscc_link_t;

   typedef enum logic [1:0] {
      TSCC_STBY = 2'b00,
      TSCC_RX   = 2'b01,
      TSCC_TX   = 2'b10
   } tscc_mode_t;

   typedef struct packed {
      logic [2:0]  en_s;
      logic [1:0]  cs_s;
      logic [1:0]  rs_s;
      logic [1:0]  lk_s;
      logic [1:0]  lv_s;
      logic [1:0]  pr_s;
      logic        rs_d;
      logic [15:0] pll;
      logic [15:0] chan;
      logic [15:0] test;
      logic        pwr_latched;
      logic        lv_latch;
      logic        cal;
      logic        pa;
      logic        txbuf;
      tscc_mode_t  mode;
      logic [1:0]  pn_s;
      logic        pin_val;
      logic        pin_oe;
      logic        adrv;
      logic        stby;
      logic        rxm;
      logic        buffer_gating_bit;
   } tscc_core_t;

   tscc_link_t lk;
   tscc_link_t next_lk;
   tscc_core_t st;
   tscc_core_t next_st;
   logic [15:0] word_sync;
   logic        load_pulse;
   logic        rs_fall;

   function automatic logic bitof(input logic [15:0] w, input int pos);
      return w[pos];
   endfunction

   // link side: shift on serial clock rise while enable low; capture on enable rise
   always_comb begin
      next_lk = lk;
      if (!load_en_in) begin
         next_lk.shreg = {lk.shreg[14:0], sdata_in};
      end
   end

   always_ff @(posedge sclk_in) begin
      lk <= next_lk;
   end

   // the shift register is frozen while enable is high, so the mclk side reads it
   // once the synchronised enable rise is seen; enable must then stay high for
   // at least three mclk cycles
   assign word_sync  = lk.shreg;
   assign load_pulse = st.en_s[1] & ~st.en_s[2];
   assign rs_fall    = st.rs_d & ~st.rs_s[1];

   always_comb begin
      next_st = st;
      next_st.en_s  = {st.en_s[1:0], load_en_in};
      next_st.pn_s  = {st.pn_s[0], shared_analog_power_pin_in};
      next_st.cs_s  = {st.cs_s[0], chip_select_pin_in};
      next_st.rs_s  = {st.rs_s[0], receive_select_in};
      next_st.lk_s  = {st.lk_s[0], pll_locked_in};
      next_st.lv_s  = {st.lv_s[0], supply_low_in};
      next_st.pr_s  = {st.pr_s[0], pa_request_in};
      next_st.rs_d  = st.rs_s[1];
      next_st.cal   = 1'b0;
      if (load_pulse) begin
         case (word_sync[1:0])
            tscc_pkg::ADDR_PLL: begin
               next_st.pll = word_sync;
            end
            tscc_pkg::ADDR_CHAN: begin
               next_st.chan = word_sync;
               next_st.cal  = 1'b1;
            end
            tscc_pkg::ADDR_TEST: begin
               next_st.test = word_sync;
            end
            default: begin
               next_st.pll = st.pll;
            end
         endcase
      end
      if (rs_fall) begin
         next_st.pwr_latched = bitof(st.pll, tscc_pkg::B_PWR_CTRL);
      end
      // set wins over the receive-select clear
      if (st.lv_s[1]) begin
         next_st.lv_latch = 1'b1;
      end else if (st.rs_s[1]) begin
         next_st.lv_latch = 1'b0;
      end
      if (!st.cs_s[1]) begin
         next_st.mode = TSCC_STBY;
      end else if (st.rs_s[1]) begin
         next_st.mode = TSCC_RX;
      end else begin
         next_st.mode = TSCC_TX;
      end
      next_st.pa = (next_st.mode == TSCC_TX) && st.lk_s[1] && st.pr_s[1]
                   && !(bitof(st.pll, tscc_pkg::B_LOCKOUT) && st.lv_latch);
      next_st.txbuf = (next_st.mode == TSCC_TX)
                      && (!bitof(st.pll, tscc_pkg::B_BUF_GATE) || next_st.pa);
      next_st.stby  = (next_st.mode == TSCC_STBY);
      next_st.rxm   = (next_st.mode == TSCC_RX);
      next_st.buffer_gating_bit   = (next_st.mode == TSCC_TX);
      // shared pin: oe high pulls it low; analog mode keeps the digital drive off
      next_st.pin_val = 1'b0;
      next_st.pin_oe  = !bitof(next_st.pll, tscc_pkg::B_ANALOG_OUTPUT_SELECT_SEL)
                        && !next_st.pwr_latched;
      next_st.adrv    = bitof(next_st.pll, tscc_pkg::B_ANALOG_OUTPUT_SELECT_SEL);
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         st      <= '0;
         st.mode <= TSCC_RX;
         st.rxm  <= 1'b1;
         // enable idles high: start the detector high so no false load follows
         st.en_s <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   assign shared_analog_power_pin_out    = st.pin_val;
   assign shared_analog_power_pin_oe_out = st.pin_oe;
   assign analog_data_drive_out          = st.adrv;
   assign standby_out            = st.stby;
   assign rx_mode_out            = st.rxm;
   assign tx_mode_out            = st.buffer_gating_bit;
   assign pa_enable_out          = st.pa;
   assign tx_buffer_on_out       = st.txbuf;
   assign cal_start_out          = st.cal;
   assign ref_divide_out         = bitof(st.pll, tscc_pkg::B_REF_DIV);
   assign charge_pump_invert_out = bitof(st.pll, tscc_pkg::B_QPP);
   assign pll_cfg_out            = st.pll[15:2];
   assign chan_int_out           = st.chan[tscc_pkg::CH_INT_HI:tscc_pkg::CH_INT_LO];
   assign chan_frac_out          = st.chan[tscc_pkg::CH_FRAC_HI:tscc_pkg::CH_FRAC_LO];
   assign manual_tune_out        = bitof(st.test, tscc_pkg::T_MAN_TUNE);
   assign filter_tune_out        = st.test[tscc_pkg::T_TUNE_HI:tscc_pkg::T_TUNE_LO];
   assign digital_probe_out      = st.test[tscc_pkg::T_DPROBE_HI:tscc_pkg::T_DPROBE_LO];
   assign analog_probe_out       = st.test[tscc_pkg::T_APROBE_HI:tscc_pkg::T_APROBE_LO];
   // transmit data pin is not routed through this block, so no retiming

   AST_STBY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !st.cs_s[1] |=> standby_out) else $error("chip select low did not give standby");
   AST_RXTX: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st.cs_s[1] && !st.rs_s[1] |=> tx_mode_out) else $error("transmit not chosen");
   AST_PA_LOCK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !st.lk_s[1] |=> !pa_enable_out) else $error("pa on while unlocked");
   AST_LOCKOUT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st.lv_latch && st.pll[tscc_pkg::B_LOCKOUT] |=> !pa_enable_out)
      else $error("pa on during lockout");
   AST_TPC_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !rs_fall |=> $stable(st.pwr_latched)) else $error("power pin moved without select fall");
   AST_CAL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      cal_start_out |-> $past(load_pulse) && $past(word_sync[1:0]) == tscc_pkg::ADDR_CHAN)
      else $error("calibration without channel write");
   AST_ADDR3: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] == 2'h3 |=> $stable(st.pll) && $stable(st.chan)
      && $stable(st.test)) else $error("address 11 changed a register");
   AST_TXBUF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      tx_buffer_on_out && st.pll[tscc_pkg::B_BUF_GATE] |-> pa_enable_out)
      else $error("buffer on without pa when gated");
   COV_CHAN: cover property (@(posedge mclk_in) cal_start_out);
   COV_TX_PA: cover property (@(posedge mclk_in) pa_enable_out);
   COV_RSFALL: cover property (@(posedge mclk_in) rs_fall);
   // pin pulled low and lockout gating reached
   COV_PIN_LOW: cover property (@(posedge mclk_in) shared_analog_power_pin_oe_out);
   COV_LOCKOUT: cover property (@(posedge mclk_in) st.lv_latch && st.pll[tscc_pkg::B_LOCKOUT]);

   // exactly one operating state at a time
   AST_ONE_MODE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      $onehot({standby_out, rx_mode_out, tx_mode_out}))
      else $error("operating state not one-hot");

   // receive chosen with chip select and receive select high
   AST_RX_SEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st.cs_s[1] && st.rs_s[1] |=> rx_mode_out)
      else $error("receive not chosen");

   // amplifier only in transmit
   AST_PA_TX: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      pa_enable_out |-> tx_mode_out)
      else $error("pa on outside transmit");

   // no amplifier in standby
   AST_STBY_PA: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      standby_out |-> !pa_enable_out && !tx_buffer_on_out)
      else $error("pa or buffer on in standby");

   // no amplifier in receive
   AST_RX_PA: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      rx_mode_out |-> !pa_enable_out)
      else $error("pa on in receive");

   // amplifier off without a request
   AST_PA_REQ: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !st.pr_s[1] |=> !pa_enable_out)
      else $error("pa on without request");

   // amplifier on when every condition is met
   AST_PA_ON: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st.cs_s[1] && !st.rs_s[1] && st.lk_s[1] && st.pr_s[1]
      && !(st.pll[tscc_pkg::B_LOCKOUT] && st.lv_latch) |=> pa_enable_out)
      else $error("pa off although enabled");

   // buffer only in transmit
   AST_TXBUF_TX: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      tx_buffer_on_out |-> tx_mode_out)
      else $error("buffer on outside transmit");

   // ungated buffer stays on through transmit
   AST_TXBUF_ON: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      tx_mode_out && !st.pll[tscc_pkg::B_BUF_GATE] && $stable(st.pll) |-> tx_buffer_on_out)
      else $error("ungated buffer off in transmit");

   // gated buffer follows the amplifier enable
   AST_TXBUF_PA: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      tx_mode_out && st.pll[tscc_pkg::B_BUF_GATE] && $stable(st.pll)
      |-> tx_buffer_on_out == pa_enable_out) else $error("gated buffer not following pa");

   // low supply sets the latch
   AST_LV_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st.lv_s[1] |=> st.lv_latch)
      else $error("lockout latch not set");

   // receive select high clears the latch
   AST_LV_CLEAR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !st.lv_s[1] && st.rs_s[1] |=> !st.lv_latch)
      else $error("lockout latch not cleared");

   // latch holds while receive select is low
   AST_LV_KEEP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st.lv_latch && !st.rs_s[1] |=> st.lv_latch)
      else $error("lockout latch dropped early");

   // analog mode never pulls the pin
   AST_ANALOG_OUTPUT_SELECT_REL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      analog_data_drive_out |-> !shared_analog_power_pin_oe_out)
      else $error("pin pulled in analog mode");

   // pin drive follows the power bit taken at the select fall
   AST_TPC_TAKE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      rs_fall && !load_pulse && !st.pll[tscc_pkg::B_ANALOG_OUTPUT_SELECT_SEL]
      |=> shared_analog_power_pin_oe_out != $past(st.pll[tscc_pkg::B_PWR_CTRL]))
      else $error("power pin did not take the power bit");

   // a pulled pin reads back low two cycles later
   AST_PIN_LOW: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      $past(shared_analog_power_pin_oe_out, 2) |-> !st.pn_s[1])
      else $error("pulled pin not low");

   // one load per enable rise
   AST_LOAD_ONE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse |=> !load_pulse)
      else $error("load pulse longer than one cycle");

   // registers move only on a load
   AST_NO_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !load_pulse |=> $stable(st.pll) && $stable(st.chan) && $stable(st.test))
      else $error("register changed without load");

   // pll word taken whole, no calibration
   AST_PLL_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] == tscc_pkg::ADDR_PLL
      |=> st.pll == $past(word_sync) && !cal_start_out) else $error("pll word not loaded");

   // channel word taken whole, with calibration
   AST_CHAN_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] == tscc_pkg::ADDR_CHAN
      |=> st.chan == $past(word_sync) && cal_start_out) else $error("channel word not loaded");

   // test word taken whole
   AST_TEST_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] == tscc_pkg::ADDR_TEST
      |=> st.test == $past(word_sync)) else $error("test word not loaded");

   // other addresses leave the pll word alone
   AST_PLL_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] != tscc_pkg::ADDR_PLL |=> $stable(st.pll))
      else $error("pll word hit by other address");

   // other addresses leave the channel word alone
   AST_CHAN_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] != tscc_pkg::ADDR_CHAN |=> $stable(st.chan))
      else $error("channel word hit by other address");

   // no calibration for other writes
   AST_CAL_OTHER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      load_pulse && word_sync[1:0] != tscc_pkg::ADDR_CHAN |=> !cal_start_out)
      else $error("calibration from other write");

   // calibration start is a single pulse
   AST_CAL_ONE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      cal_start_out |=> !cal_start_out)
      else $error("calibration pulse too long");
endmodule

// >>> tscc_pkg.sv
// tscc_pkg: constants for the transceiver serial configuration block
// assumes: used by tscc_top only, referenced with package scope
package tscc_pkg;
   localparam int          WORD_W       = 16;
   localparam int          DATA_W       = 14;
   localparam logic [1:0]  ADDR_PLL     = 2'h0;
   localparam logic [1:0]  ADDR_CHAN    = 2'h1;
   localparam logic [1:0]  ADDR_TEST    = 2'h2;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   // pll_config_word bit positions in the 16-bit word (data bit = word bit - 2)
   localparam int          B_REG_V      = 13;
   localparam int          B_DITHER     = 12;
   localparam int          B_CLIP       = 11;
   localparam int          B_LOCKOUT    = 10;
   localparam int          B_OPEN_LOOP  = 9;
   localparam int          B_BUF_GATE   = 8;
   localparam int          B_PWR_CTRL   = 7;
   localparam int          B_CW_TEST    = 6;
   localparam int          B_LO_SHIFT   = 5;
   localparam int          B_ANALOG_OUTPUT_SELECT_SEL   = 4;
   localparam int          B_REF_DIV    = 3;
   localparam int          B_QPP        = 2;
   // channel_word fields
   localparam int          CH_INT_HI    = 15;
   localparam int          CH_INT_LO    = 6;
   localparam int          CH_FRAC_HI   = 5;
   localparam int          CH_FRAC_LO   = 2;
   // test_access_word fields
   localparam int          T_MAN_TUNE   = 15;
   localparam int          T_TUNE_HI    = 14;
   localparam int          T_TUNE_LO    = 8;
   localparam int          T_DPROBE_HI  = 7;
   localparam int          T_DPROBE_LO  = 5;
   localparam int          T_APROBE_HI  = 4;
   localparam int          T_APROBE_LO  = 2;
   localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
endpackage

// >>> tscc_bb_model.sv
// tscc_bb_model: baseband controller side of the three-wire serial bus
// assumes: bus clock (6 ns) runs inside frames and for any junk clocks after them; load enable idles high
module tscc_bb_model (
   output logic sclk_out,
   output logic sdata_out,
   output logic load_en_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk_out    = 1'b0;
      sdata_out   = 1'b0;
      load_en_out = 1'b1;
   end
   // no transmit data is driven here, so no symbol run is ever too long
   // lead: surplus bits sent first; junk: clocks sent after load enable is high
   task automatic send_word(input logic [15:0] w, input int lead, input int junk);
      #1.3 load_en_out = 1'b0;
      for (int i = lead + 15; i >= 0; i--) begin
         sdata_out = (i > 15) ? ~w[i % 16] : w[i];
         #3 sclk_out = 1'b1;
         #3 sclk_out = 1'b0;
      end
      #9 sdata_out = ~sdata_out;
      load_en_out = 1'b1;
      #15;
      for (int j = 0; j < junk; j++) begin
         sdata_out = ~sdata_out;
         #3 sclk_out = 1'b1;
         #3 sclk_out = 1'b0;
      end
   endtask
   // load again without shifting: the device sees the bits already held
   task automatic reload();
      #1.3 load_en_out = 1'b0;
      #200 load_en_out = 1'b1;
   endtask
endmodule

// >>> tb_top.sv
// tb_top: self-checking bench for the serial configuration and mode block
// assumes: tscc_pkg, tscc_top and tscc_bb_model compiled before this file
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst_b, cs, rs, lock, low, pareq;
   wire         sclk, sdata, len, pin_o, pin_oe, pin_lvl;
   wire         adrv, stby, rxm, buffer_gating_bit, pa, txbuf, cal, refd, cpi, mtune;
   wire  [13:0] pll;
   wire  [9:0]  cint;
   wire  [3:0]  cfrac;
   wire  [6:0]  tune;
   wire  [2:0]  dpr, apr;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          n_cal = 0;
   // open-drain pin with pull-up
   assign pin_lvl = pin_oe ? pin_o : 1'b1;
   tscc_top tscc_top_i (
      .mclk_in(mclk), .rst_b_in(rst_b), .sclk_in(sclk), .sdata_in(sdata), .load_en_in(len),
      .chip_select_pin_in(cs), .receive_select_in(rs), .pll_locked_in(lock),
      .supply_low_in(low), .pa_request_in(pareq), .shared_analog_power_pin_in(pin_lvl),
      .shared_analog_power_pin_out(pin_o), .shared_analog_power_pin_oe_out(pin_oe),
      .analog_data_drive_out(adrv), .standby_out(stby), .rx_mode_out(rxm), .tx_mode_out(buffer_gating_bit),
      .pa_enable_out(pa), .tx_buffer_on_out(txbuf), .cal_start_out(cal), .ref_divide_out(refd),
      .charge_pump_invert_out(cpi), .pll_cfg_out(pll), .chan_int_out(cint),
      .chan_frac_out(cfrac), .manual_tune_out(mtune), .filter_tune_out(tune),
      .digital_probe_out(dpr), .analog_probe_out(apr));
   tscc_bb_model tscc_bb_model_i (.sclk_out(sclk), .sdata_out(sdata), .load_en_out(len));
   always #25 mclk = ~mclk;
   always @(posedge mclk) if (cal === 1'b1) n_cal <= n_cal + 1;
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_b(input string nm, input logic exp, input logic got);
      chk(nm, {15'h0, exp}, {15'h0, got});
   endtask
   task automatic wr(input logic [15:0] w, input int lead = 0, input int junk = 0);
      tscc_bb_model_i.send_word(w, lead, junk);
      repeat (8) @(posedge mclk);
   endtask
   task automatic set(input logic c, r, lk, lw, pq);
      @(posedge mclk);
      cs <= c;
      rs <= r;
      lock <= lk;
      low <= lw;
      pareq <= pq;
      repeat (6) @(posedge mclk);
   endtask
   task automatic t_reset();
      chk("pll_rst", 16'h0, {2'h0, pll});
      chk("chan_rst", 16'h0, {2'h0, cint, cfrac});
      chk("test_rst", 16'h0, {2'h0, mtune, tune, dpr, apr});
      chk_b("rx_rst", 1'b1, rxm);
   endtask
   task automatic t_regs();
      int n0;
      n0 = n_cal;
      wr(16'h08bc);
      chk("pll_cfg", 16'h022f, {2'h0, pll});
      chk_b("ref_div", 1'b1, refd);
      chk_b("cp_inv", 1'b1, cpi);
      wr(16'had5d, 5);
      chk("chan", 16'h2b57, {2'h0, cint, cfrac});
      chk("cal_cnt", 16'(n0 + 1), 16'(n_cal));
      wr(16'hb5ce, 0, 4);
      tscc_bb_model_i.reload();
      repeat (8) @(posedge mclk);
      chk("test", 16'h2d73, {2'h0, mtune, tune, dpr, apr});
      wr(16'hffff);
      chk("pll_keep", 16'h022f, {2'h0, pll});
      chk("chan_keep", 16'h2b57, {2'h0, cint, cfrac});
      chk("cal_cnt2", 16'(n0 + 1), 16'(n_cal));
   endtask
   task automatic t_modes();
      set(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      chk_b("stby", 1'b1, stby);
      chk_b("rx_stby", 1'b0, rxm);
      wr(16'h0890);
      chk("pll_stby", 16'h0224, {2'h0, pll});
      set(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      chk_b("tx_stby", 1'b0, buffer_gating_bit);
      set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      chk_b("tx", 1'b1, buffer_gating_bit);
      chk_b("rx_off", 1'b0, rxm);
   endtask
   task automatic t_pa();
      chk_b("pa_on", 1'b1, pa);
      chk_b("buf_on", 1'b1, txbuf);
      set(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      chk_b("pa_noreq", 1'b0, pa);
      set(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      chk_b("pa_unlock", 1'b0, pa);
      chk_b("buf_always", 1'b1, txbuf);
      set(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      chk_b("pa_lockout_enable_off", 1'b1, pa);
      set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      wr(16'h1590);
      set(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      chk_b("buf_follow", 1'b0, txbuf);
      set(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      chk_b("pa_lockout_enable", 1'b0, pa);
      set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      chk_b("pa_latched", 1'b0, pa);
      set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      chk_b("pa_cleared", 1'b1, pa);
   endtask
   task automatic t_pin();
      wr(16'h0000);
      set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      chk_b("pin_low", 1'b0, pin_lvl);
      chk_b("pin_dig", 1'b0, adrv);
      wr(16'h0080);
      set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      chk_b("pin_wait", 1'b0, pin_lvl);
      set(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      chk_b("pin_hiz", 1'b1, pin_lvl);
      wr(16'h0090);
      chk_b("pin_analog", 1'b1, adrv);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #100us;
      n_errors++;
      end_sim();
   end
   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      cs = 1'b1;
      rs = 1'b1;
      lock = 1'b1;
      low = 1'b0;
      pareq = 1'b1;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_regs();
      t_modes();
      t_pa();
      t_pin();
      end_sim();
   end
endmodule
